/* hw/dma_ll_ctrl.sv */
// List-mode and direct-mode DMA sequencing, termination and status
`timescale 1ns/1ps
`default_nettype none
module dma_ll_ctrl (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // Software control
  input wire logic START,
  input wire logic LIST_MODE_SELECT,
  input wire logic DMA_SELECT,
  input wire logic ABORT_REQUEST,
  input wire logic STOP,
  input wire logic STATUS_CLEAR,
  input wire logic PACKET_LOCATION,
  input wire logic BURST_PERMIT,
  input wire logic BACKOFF_ENABLE,
  input wire logic BACKOFF_EXPIRED,
  input wire logic CFG_WRITE,
  input wire dma_ll_pkg::seg_t CFG_SEG,
  input wire dma_ll_pkg::fetch_attr_t CFG_ATTR,
  // Packet fetch port
  output logic FETCH_REQ,
  output logic FETCH_ON_LOCAL,
  output logic FETCH_BURST,
  output logic [31:0] FETCH_ADDR,
  output dma_ll_pkg::fetch_attr_t FETCH_ATTR,
  input wire logic FETCH_VALID,
  input wire logic [31:0] FETCH_DATA,
  input wire logic FETCH_LOCAL_ERR,
  input wire logic FETCH_PCI_ERR,
  // Data mover port
  output logic MOVE_RUN,
  input wire logic MOVE_IDLE,
  input wire logic PCI_WORD_DONE,
  input wire logic PCI_ABORT,
  input wire logic LOCAL_ERR,
  // Visible state
  output logic TRANSFER_ACTIVE,
  output dma_ll_pkg::status_t STATUS,
  output dma_ll_pkg::seg_t SEG_VIEW,
  output dma_ll_pkg::fetch_attr_t ATTR_VIEW
);
  dma_ll_pkg::state_t state_q, state_d;
  dma_ll_pkg::seg_t seg_q;
  dma_ll_pkg::fetch_attr_t attr_q, saved_attr_q;
  dma_ll_pkg::status_t stat_q;
  logic [4:0] beat_q;
  logic [1:0] word_q;
  logic list_q, last_q, abort_q;

  wire active = (state_q != dma_ll_pkg::ST_IDLE);
  wire go = START && DMA_SELECT && !active;
  wire cfg_ok = CFG_WRITE && !active;
  wire fetch_err = FETCH_LOCAL_ERR || FETCH_PCI_ERR;
  wire move_err = PCI_ABORT || LOCAL_ERR;
  wire word_in = (state_q == dma_ll_pkg::ST_FETCH) && FETCH_VALID;
  wire fetch_last = word_in && (word_q == dma_ll_pkg::WORD_NEXT);
  wire list_end = last_q;
  wire count_zero = (seg_q.count == '0);
  wire resume_ok = !STOP && (!BACKOFF_ENABLE || BACKOFF_EXPIRED);
  wire seg_over = count_zero || (PCI_WORD_DONE && seg_q.count == 18'h00001);
  wire [17:0] count_dec = seg_q.count - 18'h00001;

  ////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      dma_ll_pkg::ST_IDLE: begin
        if (go) begin
          state_d = (LIST_MODE_SELECT) ? dma_ll_pkg::ST_FETCH
                                       : dma_ll_pkg::ST_MOVE;
        end
      end
      dma_ll_pkg::ST_FETCH: begin
        if (fetch_err || ABORT_REQUEST) begin
          state_d = dma_ll_pkg::ST_FINISH;
        end else if (fetch_last) begin
          state_d = dma_ll_pkg::ST_DECODE;
        end
      end
      dma_ll_pkg::ST_DECODE: begin
        if (!count_zero) begin
          state_d = dma_ll_pkg::ST_MOVE;
        end else if (list_end) begin
          state_d = dma_ll_pkg::ST_FINISH;
        end else begin
          state_d = dma_ll_pkg::ST_FETCH;
        end
      end
      dma_ll_pkg::ST_MOVE: begin
        if (move_err || ABORT_REQUEST || abort_q) begin
          state_d = dma_ll_pkg::ST_FINISH;
        end else if (seg_over) begin
          state_d = (list_q && !list_end) ? dma_ll_pkg::ST_FETCH
                                          : dma_ll_pkg::ST_FINISH;
        end else if (STOP && MOVE_IDLE) begin
          state_d = dma_ll_pkg::ST_HALT;
        end
      end
      dma_ll_pkg::ST_HALT: begin
        if (ABORT_REQUEST) begin
          state_d = dma_ll_pkg::ST_FINISH;
        end else if (resume_ok) begin
          state_d = dma_ll_pkg::ST_MOVE;
        end
      end
      dma_ll_pkg::ST_FINISH: begin
        // Wait out any bus cycle still in flight
        if (MOVE_IDLE) begin
          state_d = dma_ll_pkg::ST_IDLE;
        end
      end
      default: state_d = dma_ll_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      state_q <= dma_ll_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Packet fetch and segment registers
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      word_q <= dma_ll_pkg::WORD_PCI_ADDR;
      beat_q <= '0;
    end else if (state_q != dma_ll_pkg::ST_FETCH) begin
      word_q <= dma_ll_pkg::WORD_PCI_ADDR;
      beat_q <= '0;
    end else if (FETCH_VALID) begin
      word_q <= word_q + 2'h1;
      beat_q <= beat_q + 5'h01;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      seg_q <= '0;
      last_q <= 1'b0;
      seg_q.options <= dma_ll_pkg::OPT_RESET;
    end else if (cfg_ok) begin
      seg_q <= CFG_SEG;
    end else if (word_in) begin
      unique case (word_q)
        dma_ll_pkg::WORD_PCI_ADDR: seg_q.pci_addr <= FETCH_DATA[31:2];
        dma_ll_pkg::WORD_LOCAL_ADDR: seg_q.local_addr <= FETCH_DATA[31:2];
        dma_ll_pkg::WORD_COUNT: begin
          seg_q.options <= FETCH_DATA[31:20];
          seg_q.count <= FETCH_DATA[19:2];
        end
        dma_ll_pkg::WORD_NEXT: seg_q.next_ptr <= FETCH_DATA[31:4];
      endcase
      // end flag kept apart; it is bit 0, below the pointer bits 31:4
      if (word_q == dma_ll_pkg::WORD_NEXT) begin
        last_q <= FETCH_DATA[dma_ll_pkg::LIST_END_BIT];
      end
    end else if (state_q == dma_ll_pkg::ST_MOVE && PCI_WORD_DONE
                 && !count_zero) begin
      seg_q.count <= count_dec;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode and attribute capture
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      list_q <= 1'b0;
      attr_q <= '0;
      saved_attr_q <= '0;
    end else begin
      if (go) begin
        list_q <= LIST_MODE_SELECT;
        saved_attr_q <= attr_q;
      end
      if (cfg_ok) begin
        attr_q <= CFG_ATTR;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status flags; hardware set wins over software clear
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      stat_q <= '0;
      abort_q <= 1'b0;
    end else begin
      if (ABORT_REQUEST && active) begin
        abort_q <= 1'b1;
      end else if (state_q == dma_ll_pkg::ST_IDLE) begin
        abort_q <= 1'b0;
      end
      if (STATUS_CLEAR) begin
        stat_q.done <= 1'b0;
        stat_q.aborted <= 1'b0;
        stat_q.pci_err <= 1'b0;
        stat_q.local_err <= 1'b0;
      end
      if (state_q == dma_ll_pkg::ST_FINISH && MOVE_IDLE && !abort_q
          && !stat_q.pci_err && !stat_q.local_err) begin
        stat_q.done <= 1'b1;
      end
      if (state_q == dma_ll_pkg::ST_FINISH && MOVE_IDLE && abort_q) begin
        stat_q.aborted <= 1'b1;
      end
      if ((state_q == dma_ll_pkg::ST_MOVE && PCI_ABORT)
          || (state_q == dma_ll_pkg::ST_FETCH && FETCH_PCI_ERR)) begin
        stat_q.pci_err <= 1'b1;
      end
      if ((state_q == dma_ll_pkg::ST_MOVE && LOCAL_ERR)
          || (state_q == dma_ll_pkg::ST_FETCH && FETCH_LOCAL_ERR)) begin
        stat_q.local_err <= 1'b1;
      end
      stat_q.halted <= (state_d == dma_ll_pkg::ST_HALT);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  // fetch bus and burst choice
  assign FETCH_REQ = (state_q == dma_ll_pkg::ST_FETCH);
  assign FETCH_ON_LOCAL = PACKET_LOCATION;
  assign FETCH_BURST = !PACKET_LOCATION || BURST_PERMIT;
  assign FETCH_ADDR = {seg_q.next_ptr, 4'h0};
  assign FETCH_ATTR = saved_attr_q;
  assign MOVE_RUN = (state_q == dma_ll_pkg::ST_MOVE) && !STOP && !abort_q;
  assign TRANSFER_ACTIVE = active;
  assign STATUS = stat_q;
  assign SEG_VIEW = seg_q;
  assign ATTR_VIEW = attr_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_abort_seen;
    ABORT_REQUEST && active;
  endsequence
  sequence s_fin_idle;
    state_q == dma_ll_pkg::ST_FINISH && MOVE_IDLE;
  endsequence

  chk_abort_flag_set: assert property (@(posedge REF_CLK) disable iff (RST)
    s_abort_seen ##[1:8] s_fin_idle |=> stat_q.aborted)
    else $error("aborted flag missing after abort");
  chk_done_on_finish: assert property (@(posedge REF_CLK) disable iff (RST)
    (s_fin_idle and (!abort_q && !stat_q.pci_err && !stat_q.local_err))
    |=> stat_q.done)
    else $error("done flag not set at completion");
  chk_pci_err_flag: assert property (@(posedge REF_CLK) disable iff (RST)
    state_q == dma_ll_pkg::ST_MOVE && PCI_ABORT
    |=> stat_q.pci_err && state_q == dma_ll_pkg::ST_FINISH)
    else $error("pci error not handled");
  chk_fetch_local_err: assert property (@(posedge REF_CLK) disable iff (RST)
    state_q == dma_ll_pkg::ST_FETCH && FETCH_LOCAL_ERR
    |=> stat_q.local_err && state_q == dma_ll_pkg::ST_FINISH)
    else $error("local fetch error not handled");
  chk_count_step: assert property (@(posedge REF_CLK) disable iff (RST)
    state_q == dma_ll_pkg::ST_MOVE && PCI_WORD_DONE && !count_zero
    |=> seg_q.count == $past(seg_q.count) - 18'h00001)
    else $error("count did not step by one word");
  chk_zero_skip: assert property (@(posedge REF_CLK) disable iff (RST)
    state_q == dma_ll_pkg::ST_DECODE && count_zero && !list_end
    |=> state_q == dma_ll_pkg::ST_FETCH)
    else $error("empty packet not skipped");
  chk_halt_active: assert property (@(posedge REF_CLK) disable iff (RST)
    state_q == dma_ll_pkg::ST_HALT |-> TRANSFER_ACTIVE && stat_q.halted)
    else $error("active dropped while halted");
  chk_write_ignored: assert property (@(posedge REF_CLK) disable iff (RST)
    active && CFG_WRITE && state_q != dma_ll_pkg::ST_FETCH && !PCI_WORD_DONE
    |=> $stable(seg_q) && $stable(attr_q))
    else $error("register write accepted while active");
  chk_burst_choice: assert property (@(posedge REF_CLK) disable iff (RST)
    FETCH_REQ && PACKET_LOCATION && !BURST_PERMIT |-> !FETCH_BURST)
    else $error("burst used without permission");
  chk_fetch_beats: assert property (@(posedge REF_CLK) disable iff (RST)
    FETCH_REQ |-> beat_q < dma_ll_pkg::BEATS_PER_PACKET)
    else $error("more than four packet words fetched");
endmodule : dma_ll_ctrl
`default_nettype wire

/* include/dma_ll_pkg.sv */
// Package: constants and carrier types for the list-mode DMA controller
package dma_ll_pkg;
  localparam int unsigned CLK_MHZ = 10;
  localparam logic [4:0] BEATS_PER_PACKET = 5'h04;
  localparam logic [19:0] WORD_BYTES = 20'h00004;
  localparam int unsigned LIST_END_BIT = 0;
  localparam logic [31:0] ZERO_WORD = 32'h00000000;
  localparam logic [1:0] WORD_PCI_ADDR = 2'h0;
  localparam logic [1:0] WORD_LOCAL_ADDR = 2'h1;
  localparam logic [1:0] WORD_COUNT = 2'h2;
  localparam logic [1:0] WORD_NEXT = 2'h3;
  localparam logic [11:0] OPT_RESET = 12'h000;
  localparam logic [1:0] LOC_PCI = 2'h0;
  localparam logic [1:0] LOC_LOCAL = 2'h1;

  // Transfer settings carried with each segment
  typedef struct packed {
    logic [29:0] pci_addr;
    logic [29:0] local_addr;
    logic [11:0] options;
    logic [17:0] count;
    logic [27:0] next_ptr;
  } seg_t;

  // Fetch settings captured at list start
  typedef struct packed {
    logic [3:0] transaction_code;
    logic [1:0] destination_port_size;
    logic endian_invert;
  } fetch_attr_t;

  // Status flags
  typedef struct packed {
    logic done;
    logic aborted;
    logic pci_err;
    logic local_err;
    logic halted;
  } status_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_FETCH = 3'b001,
    ST_DECODE = 3'b011,
    ST_MOVE = 3'b010,
    ST_HALT = 3'b110,
    ST_FINISH = 3'b111
  } state_t;
endpackage : dma_ll_pkg

/* tb/dma_ll_partner.sv */
// Packet memory and data mover model facing the DMA controller
`timescale 1ns/1ps
`default_nettype none
module dma_ll_partner (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Scenario controls
  input wire logic slow,
  input wire logic fetch_fault,
  input wire logic move_fault,
  // Packet memory side
  input wire logic fetch_req,
  input wire logic fetch_on_local,
  input wire logic [31:0] fetch_addr,
  output logic fetch_valid,
  output logic [31:0] fetch_data,
  output logic fetch_local_err,
  output logic fetch_pci_err,
  // Mover side
  input wire logic move_run,
  output logic move_idle,
  output logic word_done,
  output logic pci_abort,
  output logic local_err
);
  logic [31:0] mem [0:11];
  logic [2:0] beat_q;
  initial begin
    mem = '{32'h10000000, 32'h20000000, 32'h00000008, 32'h00000010,
            32'h50000000, 32'h60000000, 32'h00000000, 32'h00000020,
            32'h30000004, 32'h40000008, 32'h00000004, 32'h00000001};
  end
  ////////////////////////////////////////////////////////////////////////
  // Released data lines toggle so stale words cannot pass for new ones
  always @(posedge clk) begin
    fetch_valid <= 1'b0;
    fetch_local_err <= 1'b0;
    fetch_pci_err <= 1'b0;
    fetch_data <= rst ? 32'h00000000 : ~fetch_data;
    if (rst || !fetch_req) begin
      beat_q <= 3'h0;
    end else if (beat_q < 3'h4) begin
      beat_q <= fetch_fault ? 3'h4 : beat_q + 3'h1;
      fetch_local_err <= fetch_fault && fetch_on_local;
      fetch_pci_err <= fetch_fault && !fetch_on_local;
      fetch_valid <= !fetch_fault;
      if (!fetch_fault) begin
        fetch_data <= mem[fetch_addr[5:2] + beat_q];
      end
    end
    // Every other cycle, so no word lands after the count runs out
    word_done <= !rst && move_run && !slow && !word_done;
    // Move fault lands on the bus the packets live on
    pci_abort <= !rst && move_run && move_fault && !fetch_on_local;
    local_err <= !rst && move_run && move_fault && fetch_on_local;
    move_idle <= rst || !move_run;
  end
endmodule : dma_ll_partner
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the list-mode DMA controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module tb;
  logic clk = 1'b0, rst = 1'b1, start = 1'b0, stop = 1'b0, abrt = 1'b0;
  logic clr = 1'b0, loc = 1'b0, burst = 1'b0, slow = 1'b0, cfgw = 1'b0;
  logic ffault = 1'b0, mfault = 1'b0, boe = 1'b0, bexp = 1'b1;
  logic lms = 1'b1, dsel = 1'b1, lerr;
  logic freq, fval, floc, fbur, ferrl, ferrp, mrun, midle, wdone, pab, act;
  logic [31:0] faddr, fdata;
  dma_ll_pkg::seg_t cseg = '0, sview;
  dma_ll_pkg::fetch_attr_t cattr = 7'h5B, fattr, aview;
  dma_ll_pkg::status_t st;
  int err_count = 0, checks = 0;
  localparam dma_ll_pkg::seg_t END_SEG = '{30'h0C000001, 30'h10000002,
    12'h000, 18'h00000, 28'h0000000};
  localparam dma_ll_pkg::seg_t P0_SEG = '{30'h04000000, 30'h08000000,
    12'h000, 18'h00002, 28'h0000001};
  dma_ll_ctrl dut (.REF_CLK(clk), .RST(rst), .START(start),
    .LIST_MODE_SELECT(lms), .DMA_SELECT(dsel), .ABORT_REQUEST(abrt),
    .STOP(stop), .STATUS_CLEAR(clr), .PACKET_LOCATION(loc),
    .BURST_PERMIT(burst), .BACKOFF_ENABLE(boe), .BACKOFF_EXPIRED(bexp),
    .CFG_WRITE(cfgw), .CFG_SEG(cseg), .CFG_ATTR(cattr), .FETCH_REQ(freq),
    .FETCH_ON_LOCAL(floc), .FETCH_BURST(fbur), .FETCH_ADDR(faddr),
    .FETCH_ATTR(fattr), .FETCH_VALID(fval), .FETCH_DATA(fdata),
    .FETCH_LOCAL_ERR(ferrl), .FETCH_PCI_ERR(ferrp), .MOVE_RUN(mrun),
    .MOVE_IDLE(midle), .PCI_WORD_DONE(wdone), .PCI_ABORT(pab),
    .LOCAL_ERR(lerr), .TRANSFER_ACTIVE(act), .STATUS(st),
    .SEG_VIEW(sview), .ATTR_VIEW(aview));
  dma_ll_partner far_end (.clk(clk), .rst(rst), .slow(slow),
    .fetch_fault(ffault), .move_fault(mfault), .fetch_req(freq),
    .fetch_on_local(floc), .fetch_addr(faddr), .fetch_valid(fval),
    .fetch_data(fdata), .fetch_local_err(ferrl), .fetch_pci_err(ferrp),
    .move_run(mrun), .move_idle(midle), .word_done(wdone),
    .pci_abort(pab), .local_err(lerr));
  initial forever #50 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  task end_of_test;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  // 0 fetch, 1 move, 2 idle, 3 halted
  task wait_for(input int w);
    int n;
    n = 0;
    while (!(w == 0 ? freq === 1'b1 : w == 1 ? mrun === 1'b1 :
             w == 2 ? act === 1'b0 : st.halted === 1'b1)) begin
      @(negedge clk);
      n++;
      if (n > 400) begin
        err_count++;
        $display("mismatch wait %0d exp 1 got 0", w);
        end_of_test();
      end
    end
  endtask : wait_for
  task go(input logic l, b, s, ff, mf);
    @(negedge clk);
    cseg = '0;
    cfgw = 1'b1;
    {loc, burst, slow, ffault, mfault} = {l, b, s, ff, mf};
    @(negedge clk);
    cfgw = 1'b0;
    start = 1'b1;
    clr = 1'b1;
    @(negedge clk);
    start = 1'b0;
    clr = 1'b0;
    wait_for(0);
    `CHK("fetch_local", l, floc)
    `CHK("fetch_burst", l ? b : 1'b1, fbur)
    `CHK("fetch_addr", 32'h00000000, faddr)
    `CHK("fetch_attr", 7'h5B, fattr)
  endtask : go
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 3; i++) begin
      go(i > 0, i == 1, 1'b0, 1'b0, 1'b0);
      wait_for(2);
      `CHK("status", 5'h10, st)
      `CHK("seg_view", END_SEG, sview)
      $display("list test %0d done", i);
    end
    for (int i = 0; i < 4; i++) begin
      go(i[0], 1'b0, 1'b0, i < 2, i > 1);
      wait_for(2);
      `CHK("status", i[0] ? 5'h02 : 5'h04, st)
      $display("fault test %0d done", i);
    end
    go(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    wait_for(1);
    cseg = '1;
    cattr = '1;
    cfgw = 1'b1;
    @(negedge clk);
    cfgw = 1'b0;
    cattr = 7'h5B;
    `CHK("seg_view", P0_SEG, sview)
    `CHK("attr_view", 7'h5B, aview)
    abrt = 1'b1;
    @(negedge clk);
    abrt = 1'b0;
    wait_for(2);
    `CHK("status", 5'h08, st)
    $display("abort test done");
    go(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    wait_for(1);
    {stop, boe, bexp} = 3'h6;
    wait_for(3);
    `CHK("active", 1'b1, act)
    {slow, stop} = 2'h0;
    repeat (5) @(negedge clk);
    `CHK("move_run", 1'b0, mrun)
    bexp = 1'b1;
    wait_for(2);
    `CHK("status_done", 1'b1, st.done)
    $display("stop test done");
    // Direct mode: select bit low refuses start, then count runs out
    @(negedge clk);
    {lms, slow, dsel, start, clr} = 5'h03;
    cseg = P0_SEG;
    cfgw = 1'b1;
    @(negedge clk);
    `CHK("active", 1'b0, act)
    {cfgw, dsel} = 2'h1;
    @(negedge clk);
    {start, clr} = 2'h0;
    wait_for(2);
    `CHK("status", 5'h10, st)
    `CHK("next_ptr", 28'h0000001, sview.next_ptr)
    `CHK("count", 18'h00000, sview.count)
    $display("direct test done");
    end_of_test();
  end
endmodule : tb
`default_nettype wire
